// file: scs_defines.svh
// Register offsets, field positions and reset values for the system clock source select
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH

`define SCS_ADDR_W 8
`define SCS_OFF_SYSCTRL 8'h00
`define SCS_OFF_PLLCTRL 8'h04
`define SCS_OFF_PLLDIV 8'h08
`define SCS_OFF_STATUS 8'h0C

`define SCS_SEL_LSB 0
`define SCS_VCOBYP_BIT 0
`define SCS_OSCINT_BIT 1
`define SCS_PRESCALER_DIVIDER_FIELD_LSB 16
`define SCS_PLL_INPUT_DIVIDER_FIELD_LSB 0
`define SCS_PLL_MULTIPLIER_FIELD_LSB 8
`define SCS_PLL_OUTPUT_DIVIDER_FIELD_LSB 16
`define SCS_STAT_CLK_BIT 2
`define SCS_STAT_PER_LSB 16

`define SCS_RST_SEL 2'h0
`define SCS_RST_VCOBYP 1'h1
`define SCS_RST_OSCINT 1'h0
`define SCS_RST_PRESCALER_DIVIDER_FIELD 10'h000
`define SCS_RST_PLL_INPUT_DIVIDER_FIELD 4'h0
`define SCS_RST_PLL_MULTIPLIER_FIELD 7'h00
`define SCS_RST_PLL_OUTPUT_DIVIDER_FIELD 10'h000

`endif

// file: scs_pkg.sv
// Types shared by the system clock source select block
package scs_pkg;
  typedef enum logic [1:0] {
    SCS_SRC_WAKEUP = 2'h0,
    SCS_SRC_RSVD = 2'h1,
    SCS_SRC_OSC = 2'h2,
    SCS_SRC_DIRECT = 2'h3
  } scs_src_t;
  // Gray coded generation methods
  typedef enum logic [1:0] {
    SCS_M_WAKE = 2'h0,
    SCS_M_PRESC = 2'h1,
    SCS_M_PLL = 2'h3,
    SCS_M_DIRECT = 2'h2
  } scs_method_t;
endpackage

// file: scs_sync.sv
// Two flip-flop synchroniser for clock pins sampled on ref_clk
`timescale 1ns/1ps
module scs_sync #(
  parameter int W = 4
) (
  input wire logic ref_clk,          // Sampling clock
  input wire logic rst_n,            // Asynchronous reset, active low
  input wire logic [W-1:0] async_in, // Pin levels
  output logic [W-1:0] sync_out      // Synchronised levels
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

// file: scs_top.sv
// System clock source select: direct drive, prescaler, PLL and wakeup clock generation
`timescale 1ns/1ps
`include "scs_defines.svh"
module scs_top
  import scs_pkg::*;
#(
  parameter int K1_W = 10,
  parameter int PLL_INPUT_DIVIDER_FIELD_W = 4,
  parameter int PLL_MULTIPLIER_FIELD_W = 7,
  parameter int K2_W = 10,
  parameter int PER_W = 16
) (
  input wire logic ref_clk,                      // 125 MHz sampling clock
  input wire logic rst_n,                        // Asynchronous reset, active low
  input wire logic direct_clock_input,           // Direct drive clock pin
  input wire logic crystal_input_pin,            // Crystal oscillator clock pin
  input wire logic internal_osc_in,              // On-chip clock source
  input wire logic wakeup_clk_in,                // Low-frequency wakeup clock
  input wire logic [`SCS_ADDR_W-1:0] reg_addr,   // Register byte address
  input wire logic [31:0] reg_wdata,             // Write data
  input wire logic reg_wr,                       // Write strobe
  input wire logic reg_rd,                       // Read strobe
  output logic [31:0] reg_rdata,                 // Read data, cycle after strobe
  output logic sys_clk_out,                      // Generated system clock level
  output logic sys_clk_tick                      // One-cycle pulse per system clock rise
);
  localparam int ACC_W = PER_W + PLL_INPUT_DIVIDER_FIELD_W + K2_W + 3;

  logic [3:0] pin_s;
  logic [1:0] clock_source_select_reg;
  logic vco_bypass_select_reg;
  logic osc_int_sel_reg;
  logic [K1_W-1:0] prescaler_divider_field_reg;
  logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] pll_input_divider_field_reg;
  logic [PLL_MULTIPLIER_FIELD_W-1:0] pll_multiplier_field_reg;
  logic [K2_W-1:0] pll_output_divider_field_reg;
  scs_src_t active_src_reg;
  logic osc_d_reg;
  logic [K1_W-1:0] presc_cnt_reg;
  logic [PER_W-1:0] per_cnt_reg;
  logic [PER_W-1:0] per_reg;
  logic [ACC_W-1:0] acc_reg;
  logic pll_clk_reg;
  logic sys_clk_reg;
  logic sys_tick_reg;
  logic [31:0] rdata_reg;

  // Threshold of the PLL accumulator: input period times P times K2
  function automatic logic [ACC_W-1:0] pll_thresh(input logic [PER_W-1:0] per,
    input logic [PLL_INPUT_DIVIDER_FIELD_W-1:0] pll_input_divider_field, input logic [K2_W-1:0] pll_output_divider_field);
    logic [ACC_W-1:0] p;
    logic [ACC_W-1:0] k;
    p = ACC_W'(pll_input_divider_field) + ACC_W'(1);
    k = ACC_W'(pll_output_divider_field) + ACC_W'(1);
    pll_thresh = ACC_W'(ACC_W'(per) * p * k);
  endfunction

  // Every pin clock is sampled through two flops before use
  scs_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({wakeup_clk_in, internal_osc_in, crystal_input_pin, direct_clock_input}),
    .sync_out(pin_s)
  );

  // Register decode
  wire wr_sys = reg_wr && (reg_addr == `SCS_OFF_SYSCTRL);
  wire wr_pll = reg_wr && (reg_addr == `SCS_OFF_PLLCTRL);
  wire wr_div = reg_wr && (reg_addr == `SCS_OFF_PLLDIV);
  wire [1:0] sel_wr = reg_wdata[`SCS_SEL_LSB +: 2];

  // Oscillator is crystal or internal source; edge seen on synced level
  wire osc_s = osc_int_sel_reg ? pin_s[2] : pin_s[1];
  wire osc_rise = osc_s && !osc_d_reg;

  // Generation method from active source and bypass bit
  wire scs_method_t method =
    (active_src_reg == SCS_SRC_DIRECT) ? SCS_M_DIRECT :
    (active_src_reg == SCS_SRC_WAKEUP) ? SCS_M_WAKE :
    vco_bypass_select_reg ? SCS_M_PRESC : SCS_M_PLL;

  // Prescaler: high for the first half of K1 oscillator periods
  wire [K1_W:0] k1_half = ({1'b0, prescaler_divider_field_reg} + (K1_W+1)'(2)) >> 1;
  wire presc_high = ({1'b0, presc_cnt_reg} < k1_half);
  wire presc_wrap = (presc_cnt_reg >= prescaler_divider_field_reg);

  // PLL: accumulator steps 2N each cycle, toggles at period*P*K2
  wire [ACC_W-1:0] thresh = pll_thresh(per_reg, pll_input_divider_field_reg,
    pll_output_divider_field_reg);
  wire [ACC_W-1:0] step = ACC_W'({pll_multiplier_field_reg, 1'b0}) + ACC_W'(2);
  wire [ACC_W-1:0] acc_sum = acc_reg + step;
  wire pll_hit = (thresh != '0) && (acc_sum >= thresh);

  // System clock selection
  logic sys_next;
  always_comb
  begin
    case (method)
      SCS_M_DIRECT: sys_next = pin_s[0];
      SCS_M_WAKE: sys_next = pin_s[3];
      SCS_M_PRESC: sys_next = (prescaler_divider_field_reg == '0) ? osc_s : presc_high;
      SCS_M_PLL: sys_next = pll_clk_reg;
      default: sys_next = 1'b0;
    endcase
  end

  // Status and read data mux; unmapped addresses read zero
  wire [31:0] rd_word =
    (reg_addr == `SCS_OFF_SYSCTRL) ? {30'h0, clock_source_select_reg} :
    (reg_addr == `SCS_OFF_PLLCTRL) ? (32'(prescaler_divider_field_reg) << `SCS_PRESCALER_DIVIDER_FIELD_LSB)
      | (32'(osc_int_sel_reg) << `SCS_OSCINT_BIT) | 32'(vco_bypass_select_reg) :
    (reg_addr == `SCS_OFF_PLLDIV) ? (32'(pll_output_divider_field_reg) << `SCS_PLL_OUTPUT_DIVIDER_FIELD_LSB)
      | (32'(pll_multiplier_field_reg) << `SCS_PLL_MULTIPLIER_FIELD_LSB) | 32'(pll_input_divider_field_reg) :
    (reg_addr == `SCS_OFF_STATUS) ? (32'(per_reg) << `SCS_STAT_PER_LSB)
      | (32'(sys_clk_reg) << `SCS_STAT_CLK_BIT) | 32'(method) :
    32'h0;

  // Control registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_source_select_reg <= `SCS_RST_SEL;
      vco_bypass_select_reg <= `SCS_RST_VCOBYP;
      osc_int_sel_reg <= `SCS_RST_OSCINT;
      prescaler_divider_field_reg <= `SCS_RST_PRESCALER_DIVIDER_FIELD;
      pll_input_divider_field_reg <= `SCS_RST_PLL_INPUT_DIVIDER_FIELD;
      pll_multiplier_field_reg <= `SCS_RST_PLL_MULTIPLIER_FIELD;
      pll_output_divider_field_reg <= `SCS_RST_PLL_OUTPUT_DIVIDER_FIELD;
    end
    else
    begin
      if (wr_sys)
        clock_source_select_reg <= sel_wr;
      if (wr_pll)
      begin
        vco_bypass_select_reg <= reg_wdata[`SCS_VCOBYP_BIT];
        osc_int_sel_reg <= reg_wdata[`SCS_OSCINT_BIT];
        prescaler_divider_field_reg <= reg_wdata[`SCS_PRESCALER_DIVIDER_FIELD_LSB +: K1_W];
      end
      if (wr_div)
      begin
        pll_input_divider_field_reg <= reg_wdata[`SCS_PLL_INPUT_DIVIDER_FIELD_LSB +: PLL_INPUT_DIVIDER_FIELD_W];
        pll_multiplier_field_reg <= reg_wdata[`SCS_PLL_MULTIPLIER_FIELD_LSB +: PLL_MULTIPLIER_FIELD_W];
        pll_output_divider_field_reg <= reg_wdata[`SCS_PLL_OUTPUT_DIVIDER_FIELD_LSB +: K2_W];
      end
    end
  end

  // Active source follows the field, except the reserved code leaves it alone
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      active_src_reg <= SCS_SRC_WAKEUP;
    else if (clock_source_select_reg != SCS_SRC_RSVD)
      active_src_reg <= scs_src_t'(clock_source_select_reg);
  end

  // Prescaler counter advances on oscillator rising edges
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_d_reg <= 1'b0;
      presc_cnt_reg <= '0;
    end
    else
    begin
      osc_d_reg <= osc_s;
      if (osc_rise)
        presc_cnt_reg <= presc_wrap ? '0 : presc_cnt_reg + K1_W'(1);
    end
  end

  // Input period measurement, saturating so a stopped source cannot wrap
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      per_cnt_reg <= '0;
      per_reg <= '0;
    end
    else if (osc_rise)
    begin
      per_reg <= (per_cnt_reg == '1) ? per_cnt_reg : per_cnt_reg + PER_W'(1);
      per_cnt_reg <= '0;
    end
    else if (per_cnt_reg != '1)
      per_cnt_reg <= per_cnt_reg + PER_W'(1);
  end

  // PLL synthesis; output capped at half of ref_clk since one toggle per cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_reg <= '0;
      pll_clk_reg <= 1'b0;
    end
    else if (pll_hit)
    begin
      acc_reg <= acc_sum - thresh;
      pll_clk_reg <= !pll_clk_reg;
    end
    else if (thresh != '0)
      acc_reg <= acc_sum;
  end

  // System clock and its rise pulse, which downstream logic uses as its timebase
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sys_clk_reg <= 1'b0;
      sys_tick_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      sys_clk_reg <= sys_next;
      sys_tick_reg <= sys_next && !sys_clk_reg;
      rdata_reg <= reg_rd ? rd_word : 32'h0;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sys_clk_out = sys_clk_reg;
  assign sys_clk_tick = sys_tick_reg;
endmodule

// file: scs_top_chk.sv
// Port checker for the system clock source select block
`timescale 1ns/1ps
module scs_top_chk (
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic direct_clock_input, // Direct pin
  input wire logic crystal_input_pin, // Crystal pin
  input wire logic internal_osc_in, // On-chip source
  input wire logic wakeup_clk_in, // Wakeup clock
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic sys_clk_out, // System clock
  input wire logic sys_clk_tick // Rise pulse
);
  logic [1:0] sel_reg;
  logic [2:0] cnt_reg;
  logic byp_reg, int_reg, k1z_reg;
  wire ok = cnt_reg == 3'h7;
  wire osc = int_reg ? internal_osc_in : crystal_input_pin;
  wire [1:0] meth = sel_reg == 2'h3 ? 2'h2 : sel_reg == 2'h2 ? {~byp_reg, 1'b1} : 2'h0;
  // Shadow fields; settle count hides the switch-over latency after any write
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sel_reg <= 2'h0;
      {byp_reg, int_reg, k1z_reg} <= 3'h5;
      cnt_reg <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] != 2'h1) sel_reg <= reg_wdata[1:0];
      if (reg_wr && reg_addr == 8'h04) {byp_reg, int_reg, k1z_reg} <= {reg_wdata[0],
        reg_wdata[1], reg_wdata[25:16] == 10'h000};
      cnt_reg <= reg_wr ? 3'h0 : cnt_reg + {2'h0, ~ok};
    end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_direct_follow: assert property (ok && sel_reg == 2'h3 |->
    sys_clk_out == $past(direct_clock_input, 3))
    else $error("direct clock not followed");
  chk_wake_follow: assert property (ok && sel_reg == 2'h0 |->
    sys_clk_out == $past(wakeup_clk_in, 3))
    else $error("wakeup clock not followed");
  chk_presc_pass: assert property (ok && sel_reg == 2'h2 && byp_reg && k1z_reg |->
    sys_clk_out == $past(osc, 3))
    else $error("factor one not a pass through");
  chk_tick_rise: assert property (sys_clk_tick |-> sys_clk_out && !$past(sys_clk_out))
    else $error("tick without a rise");
  chk_rise_tick: assert property ($rose(sys_clk_out) |-> sys_clk_tick)
    else $error("rise without a tick");
  chk_tick_single: assert property (sys_clk_tick |=> !sys_clk_tick)
    else $error("tick longer than one cycle");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_method_kept: assert property ($past(reg_rd) && $past(reg_addr) == 8'h0C && $past(ok)
    |-> reg_rdata[1:0] == meth)
    else $error("active method wrong");
endmodule
bind scs_top scs_top_chk scs_top_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .direct_clock_input(direct_clock_input), .crystal_input_pin(crystal_input_pin),
  .internal_osc_in(internal_osc_in), .wakeup_clk_in(wakeup_clk_in), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sys_clk_out(sys_clk_out), .sys_clk_tick(sys_clk_tick));

// file: scs_clk_src.sv
// Free-running clock sources seen by the clock select block
`timescale 1ns/1ps
module scs_clk_src (
  output logic d_clk, // Direct clock, 40 ns
  output logic x_clk, // Crystal clock, 64 ns
  output logic i_clk, // On-chip clock, 48 ns
  output logic w_clk // Wakeup clock, 80 ns
);
  // Edges sit 1 ns off the grid so sampling never races them
  initial
  begin
    {d_clk, x_clk, i_clk, w_clk} = 4'h0;
    #1;
    fork
      forever #20 d_clk = ~d_clk;
      forever #32 x_clk = ~x_clk;
      forever #24 i_clk = ~i_clk;
      forever #40 w_clk = ~w_clk;
    join
  end
endmodule

// file: scs_top_test.sv
// Self-checking bench for the system clock source select block
`timescale 1ns/1ps
module scs_top_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rnd = 32'hC285;
  logic d_clk, x_clk, i_clk, w_clk, sys_clk_out, sys_clk_tick;
  logic [63:0] note_q[$];
  int num_errors = 0;
  int num_checks = 0;
  always #4 ref_clk = ~ref_clk;
  scs_clk_src scs_clk_src_i (.d_clk(d_clk), .x_clk(x_clk), .i_clk(i_clk), .w_clk(w_clk));
  scs_top scs_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .direct_clock_input(d_clk),
    .crystal_input_pin(x_clk), .internal_osc_in(i_clk), .wakeup_clk_in(w_clk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_clk_out(sys_clk_out), .sys_clk_tick(sys_clk_tick));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  // Strobes drop for a cycle after each access, so no signal is set twice per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back({m, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Read data stands only in the cycle after the strobe; compare the oldest note there
  always @(posedge ref_clk) rd_d <= reg_rd;
  always @(negedge ref_clk)
    if (rd_d === 1'b1)
    begin
      logic [63:0] n;
      n = note_q.pop_front();
      check(reg_rdata & n[63:32], n[31:0]);
    end
  // Eight cycles let a switch settle, so a glitch rise at the switch is never a start point
  task automatic measure(input int n, input int exp);
    int c, t, g;
    c = 0;
    t = -1;
    g = 0;
    repeat (8) @(posedge ref_clk);
    while (t < n && g < 40000)
    begin
      @(posedge ref_clk);
      g++;
      if (t >= 0) c++;
      if (sys_clk_tick === 1'b1) t++;
    end
    check(32'(c), 32'(n * exp));
    $display("Period test done, %0d cycles", c);
  endtask
  initial
  begin
    logic [9:0] f;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(8'h00, 32'h0, 32'hFFFFFFFF);
    rd(8'h04, 32'h1, 32'hFFFFFFFF);
    rd(8'h08, 32'h0, 32'hFFFFFFFF);
    rd(8'h10, 32'h0, 32'hFFFFFFFF);
    measure(4, 10);
    wr(8'h00, 32'h3);
    measure(4, 5);
    wr(8'h00, 32'h1);
    measure(4, 5);
    rd(8'h0C, 32'h2, 32'h3);
    wr(8'h04, 32'h1);
    wr(8'h00, 32'h2);
    measure(4, 8);
    wr(8'h04, 32'h3);
    measure(4, 6);
    rnd = xs(rnd);
    f = {6'h00, rnd[3:0]};
    wr(8'h04, {6'h00, f, 16'h0001});
    measure(2, 8 * (int'(f) + 1));
    wr(8'h04, {6'h00, 10'h3FF, 16'h0001});
    measure(1, 8192);
    rd(8'h0C, 32'h1, 32'h3);
    wr(8'h08, 32'h00010300);
    wr(8'h04, 32'h0);
    measure(8, 4);
    rd(8'h0C, 32'h3, 32'h3);
    give_verdict();
  end
  // Watchdog at 50k cycles, about three times the longest expected run
  initial
  begin
    #400000;
    num_errors++;
    give_verdict();
  end
endmodule
